/* rtl/cfg_decode_pkg.sv */
// package: field layout, offsets and codes of the configuration words
`default_nettype none
package cfg_decode_pkg;
    // register offsets of the plain register port (byte addresses)
    localparam logic [3:0] OFS_PROTECT_DEBUG = 4'h0;
    localparam logic [3:0] OFS_CLOCK_WATCHDOG = 4'h4;
    localparam logic [3:0] OFS_STATUS = 4'h8;
    localparam logic [3:0] OFS_SCAN_CTRL = 4'hc;
    // word 0 field positions
    localparam int W0_CODE_PROTECT = 28;
    localparam int W0_BOOT_WP = 24;
    localparam int W0_PWP_LSB = 10;
    localparam int PWP_WIDTH = 10;
    localparam int W0_PAIR_LSB = 3;
    localparam int W0_SCAN_EN = 2;
    localparam int W0_DEBUG_LSB = 0;
    // word 1 field positions
    localparam int W1_WIN_LSB = 24;
    localparam int W1_WDT_EN = 23;
    localparam int W1_NONWIN = 22;
    localparam int W1_PS_LSB = 16;
    localparam int W1_CKSM_LSB = 14;
    localparam int W1_PBDIV_LSB = 12;
    localparam int W1_CLOCK_OUT_SIGNAL_N = 10;
    localparam int W1_POSC_LSB = 8;
    localparam int W1_TWO_SPEED = 7;
    localparam int W1_SOSC_EN = 5;
    localparam int W1_NOSC_LSB = 0;
    // page size and largest postscale code
    localparam logic [19:0] PAGE_BYTES = 20'h00400;
    localparam logic [4:0] PS_MAX = 5'h14;
    // reset values of the captured words: all ones, all protection off
    localparam logic [31:0] WORD_RESET = 32'hffffffff;
    // window sizes in eighths of the period
    localparam logic [2:0] WIN_25 = 3'h2;
    localparam logic [2:0] WIN_37 = 3'h3;
    localparam logic [2:0] WIN_50 = 3'h4;
    localparam logic [2:0] WIN_75 = 3'h6;

    typedef enum logic [1:0] {
        POSC_EXT_CLK = 2'b00,
        POSC_STD_XTAL = 2'b01,
        POSC_HS_XTAL = 2'b10,
        POSC_OFF = 2'b11
    } posc_mode_t;

    typedef enum logic [2:0] {
        OSC_FAST_RC = 3'b000,
        OSC_FRC_DIV_PLL = 3'b001,
        OSC_PRIMARY = 3'b010,
        OSC_PRIMARY_PLL = 3'b011,
        OSC_SECONDARY = 3'b100,
        OSC_LOW_POWER_RC = 3'b101,
        OSC_FRC_DIV16 = 3'b110,
        OSC_FRC_DIVIDED = 3'b111
    } osc_sel_t;

    typedef enum logic [1:0] {
        LOAD_IDLE = 2'b00,
        LOAD_CAPTURE = 2'b01,
        LOAD_DONE = 2'b10
    } load_state_t;

    // decoded protection and debug settings
    typedef struct packed {
        logic [19:0] protectLimit;
        logic pageProtectOn;
        logic bootWritable;
        logic codeProtectOn;
        logic [1:0] debugPair;
        logic scanPortEnable;
        logic debuggerEnable;
    } protect_cfg_t;

    // decoded clock and watchdog settings
    typedef struct packed {
        logic [2:0] windowEighths;
        logic watchdogForced;
        logic windowMode;
        logic [4:0] postscaleShift;
        logic clockSwitchEn;
        logic failSafeEn;
        logic [3:0] periphDivisor;
        logic clockOutActive;
        posc_mode_t primaryOscMode;
        logic twoSpeedStartup;
        logic secondaryOscEn;
        osc_sel_t initialOsc;
    } clock_cfg_t;
endpackage : cfg_decode_pkg
`default_nettype wire

/* rtl/cfg_word_store.sv */
// small memory holding the captured configuration words
`default_nettype none
module cfg_word_store #(
    parameter int DEPTH = 2,
    parameter int WIDTH = 32
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic writeEnable,
    input wire logic [0:0] writeIndex,
    input wire logic [WIDTH-1:0] writeData,
    input wire logic [0:0] readIndex,
    output logic [WIDTH-1:0] readData
);
    initial begin
        if (DEPTH != 2 || WIDTH < 1) begin
            $error("cfg_word_store: DEPTH must be 2");
        end
    end

    logic [WIDTH-1:0] words [DEPTH];

    // storage resets to erased flash, all ones
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            words[0] <= '1;
            words[1] <= '1;
        end else if (writeEnable) begin
            words[writeIndex] <= writeData;
        end
    end

    // registered read port
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            readData <= '1;
        end else begin
            readData <= words[readIndex];
        end
    end
endmodule // cfg_word_store
`default_nettype wire

/* rtl/config_word_decoder.sv */
// configuration word loader and decoder
// Function
// - page protect field is ones' complement of page count; all ones disables.
// - each page is 0x400 bytes; memory below count times page is protected.
// - page protection acts only while boot write-protect bit 24 is clear.
// - debug pair 1 for 11, pair 2 for 10, pair 3 for 01; 00 reserved.
// - scan enable bit 2 enables scan port and seeds runtime scan enable.
// - debugger disabled when upper bit set; forced off under code protection.
// - window size 25, 37.5, 50, 75 percent for codes 11, 10, 01, 00.
// - watchdog enable bit forces watchdog on; else software may start it.
// - watchdog mode bit 1 selects non-window, 0 selects window operation.
// - postscale code n gives ratio one to two to the n.
// - postscale codes above 10100 behave as 10100.
// - switch/monitor field: 1x none, 01 switching only, 00 both.
// - peripheral bus clock is system clock divided by 1, 2, 4 or 8.
// - clock out active when enable_n is 0 and primary mode 11 or 00.
// - primary mode: 11 off, 10 high-speed, 01 standard crystal, 00 external.
// - switchover bit enables two-speed start-up when 1.
// - secondary oscillator enabled when its bit is 1.
// - initial oscillator field selects one of eight clock sources.
// - boot write-protect bit 0 makes boot flash non-writable.
// - code-protect bit 0 blocks external read and modify of flash.
//
// The address-and-strobe port and the address map were chosen for this implementation.
`default_nettype none
module config_word_decoder (
    input wire logic clock,
    input wire logic reset,
    input wire logic [31:0] nvWordProtectDebug,
    input wire logic [31:0] nvWordClockWatchdog,
    input wire logic [3:0] address,
    input wire logic [31:0] writeData,
    input wire logic writeStrobe,
    input wire logic readStrobe,
    output logic [31:0] readData,
    input wire logic watchdogSoftEnable,
    output logic configValid,
    output cfg_decode_pkg::protect_cfg_t protectCfg,
    output cfg_decode_pkg::clock_cfg_t clockCfg,
    output logic watchdogRunning,
    output logic runtimeScanEnable,
    output logic clockOutDrive
);
    // loader state: captures word 0, then word 1, then stays done
    cfg_decode_pkg::load_state_t state;
    cfg_decode_pkg::load_state_t next_state;
    logic [0:0] loadIndex;
    logic [0:0] next_loadIndex;
    logic storeWrite;
    logic [0:0] storeReadIndex;
    logic [31:0] storeReadData;
    logic [31:0] word0;
    logic [31:0] word1;

    // divisor from the two-bit field, used only by the clock decode, not by readback
    function automatic logic [3:0] divisorOf(input logic [1:0] code);
        divisorOf = 4'h1 << code;
    endfunction

    // postscale code clamped to the largest defined value
    function automatic logic [4:0] clampPs(input logic [4:0] code);
        clampPs = (code > cfg_decode_pkg::PS_MAX) ?
            cfg_decode_pkg::PS_MAX : code;
    endfunction

    // capture sequence: the words are sampled while reset is released
    // and are never taken again until the next reset
    always_comb begin
        next_state = state;
        next_loadIndex = loadIndex;
        case (state)
            cfg_decode_pkg::LOAD_IDLE: begin
                next_state = cfg_decode_pkg::LOAD_CAPTURE;
                next_loadIndex = 1'b0;
            end
            cfg_decode_pkg::LOAD_CAPTURE: begin
                if (loadIndex == 1'b1) begin
                    next_state = cfg_decode_pkg::LOAD_DONE;
                end
                next_loadIndex = 1'b1;
            end
            cfg_decode_pkg::LOAD_DONE: begin
                next_state = cfg_decode_pkg::LOAD_DONE;
            end
            default: begin
                next_state = cfg_decode_pkg::LOAD_IDLE;
            end
        endcase
    end

    // store only written by the loader, never by the bus
    assign storeWrite = (state == cfg_decode_pkg::LOAD_CAPTURE);

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            state <= cfg_decode_pkg::LOAD_IDLE;
            loadIndex <= 1'b0;
        end else begin
            state <= next_state;
            loadIndex <= next_loadIndex;
        end
    end

    cfg_word_store #(
        .DEPTH(2),
        .WIDTH(32)
    ) u_store (
        .clock(clock),
        .reset(reset),
        .writeEnable(storeWrite),
        .writeIndex(loadIndex),
        .writeData(loadIndex == 1'b0 ? nvWordProtectDebug
                                     : nvWordClockWatchdog),
        .readIndex(storeReadIndex),
        .readData(storeReadData)
    );

    // flop copies for the decoders, taken at the same edges as the store
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            word0 <= cfg_decode_pkg::WORD_RESET;
            word1 <= cfg_decode_pkg::WORD_RESET;
        end else if (storeWrite && loadIndex == 1'b0) begin
            word0 <= nvWordProtectDebug;
        end else if (storeWrite && loadIndex == 1'b1) begin
            word1 <= nvWordClockWatchdog;
        end
    end

    // word 0 field decode
    wire logic [9:0] pwpField = word0[cfg_decode_pkg::W0_PWP_LSB +: 10];
    wire logic [9:0] pageCount = ~pwpField;
    wire logic bootWp = word0[cfg_decode_pkg::W0_BOOT_WP];
    wire logic codeProt = ~word0[cfg_decode_pkg::W0_CODE_PROTECT];
    wire logic [1:0] pairCode = word0[cfg_decode_pkg::W0_PAIR_LSB +: 2];
    wire logic [1:0] dbgField = codeProt ? 2'b11
        : word0[cfg_decode_pkg::W0_DEBUG_LSB +: 2];
    wire logic [19:0] limit = 20'(pageCount) * cfg_decode_pkg::PAGE_BYTES;

    // pair 1 for 11, pair 2 for 10, pair 3 for 01, none for reserved 00
    wire logic [1:0] pairNumber = (pairCode == 2'b00) ? 2'h0
        : 2'(2'h3 - pairCode + 2'h1);

    // word 1 field decode
    wire logic [1:0] winCode = word1[cfg_decode_pkg::W1_WIN_LSB +: 2];
    wire logic [1:0] cksm = word1[cfg_decode_pkg::W1_CKSM_LSB +: 2];
    wire logic [1:0] posc = word1[cfg_decode_pkg::W1_POSC_LSB +: 2];
    wire logic clkoN = word1[cfg_decode_pkg::W1_CLOCK_OUT_SIGNAL_N];
    wire logic wdtForced = word1[cfg_decode_pkg::W1_WDT_EN];

    // window size in eighths of the watchdog period
    logic [2:0] winEighths;
    always_comb begin
        case (winCode)
            2'b11: winEighths = cfg_decode_pkg::WIN_25;
            2'b10: winEighths = cfg_decode_pkg::WIN_37;
            2'b01: winEighths = cfg_decode_pkg::WIN_50;
            default: winEighths = cfg_decode_pkg::WIN_75;
        endcase
    end

    // clock out needs primary off or external clock
    wire logic clkoOk = ~clkoN &&
        (posc == 2'b11 || posc == 2'b00);

    // outputs are registered once loading is done, so they hold still
    wire logic loaded = (state == cfg_decode_pkg::LOAD_DONE);

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            protectCfg <= '0;
        end else if (loaded && !configValid) begin
            protectCfg.protectLimit <= limit;
            protectCfg.pageProtectOn <= (pwpField != 10'h3ff)
                && !bootWp;
            protectCfg.bootWritable <= bootWp;
            protectCfg.codeProtectOn <= codeProt;
            protectCfg.debugPair <= pairNumber;
            protectCfg.scanPortEnable <=
                word0[cfg_decode_pkg::W0_SCAN_EN];
            protectCfg.debuggerEnable <= ~dbgField[1];
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            clockCfg <= '0;
        end else if (loaded && !configValid) begin
            clockCfg.windowEighths <= winEighths;
            clockCfg.watchdogForced <= wdtForced;
            clockCfg.windowMode <=
                ~word1[cfg_decode_pkg::W1_NONWIN];
            clockCfg.postscaleShift <= clampPs(
                word1[cfg_decode_pkg::W1_PS_LSB +: 5]);
            clockCfg.clockSwitchEn <= ~cksm[1];
            clockCfg.failSafeEn <= (cksm == 2'b00);
            clockCfg.periphDivisor <= divisorOf(
                word1[cfg_decode_pkg::W1_PBDIV_LSB +: 2]);
            clockCfg.clockOutActive <= clkoOk;
            clockCfg.primaryOscMode <=
                cfg_decode_pkg::posc_mode_t'(posc);
            clockCfg.twoSpeedStartup <=
                word1[cfg_decode_pkg::W1_TWO_SPEED];
            clockCfg.secondaryOscEn <=
                word1[cfg_decode_pkg::W1_SOSC_EN];
            clockCfg.initialOsc <= cfg_decode_pkg::osc_sel_t'(
                word1[cfg_decode_pkg::W1_NOSC_LSB +: 3]);
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            configValid <= 1'b0;
        end else if (loaded) begin
            configValid <= 1'b1;
        end
    end

    // runtime scan enable: seeded from the word, then software owns it
    logic scanCtrlWrite;
    assign scanCtrlWrite = writeStrobe &&
        address == cfg_decode_pkg::OFS_SCAN_CTRL && configValid;

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            runtimeScanEnable <= 1'b0;
        end else if (loaded && !configValid) begin
            runtimeScanEnable <=
                word0[cfg_decode_pkg::W0_SCAN_EN];
        end else if (scanCtrlWrite) begin
            runtimeScanEnable <= writeData[0];
        end
    end

    // software cannot stop a forced watchdog; otherwise it may run it
    assign watchdogRunning = configValid &&
        (clockCfg.watchdogForced || watchdogSoftEnable);

    // clock drive only after the settings are final
    assign clockOutDrive = configValid && clockCfg.clockOutActive;

    // register reads: store answers one cycle later, others are muxed
    // here so all data lands in the same cycle; writes to the words
    // are dropped since the store has no bus write path
    assign storeReadIndex = (address == cfg_decode_pkg::OFS_CLOCK_WATCHDOG);

    logic [3:0] readAddr;
    logic readPending;
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            readAddr <= 4'h0;
            readPending <= 1'b0;
        end else begin
            readAddr <= address;
            readPending <= readStrobe;
        end
    end

    wire logic [31:0] statusWord = {30'h0, configValid, runtimeScanEnable};

    always_comb begin
        readData = 32'h0;
        if (readPending) begin
            case (readAddr)
                cfg_decode_pkg::OFS_PROTECT_DEBUG,
                cfg_decode_pkg::OFS_CLOCK_WATCHDOG: begin
                    readData = storeReadData;
                end
                cfg_decode_pkg::OFS_STATUS: readData = statusWord;
                cfg_decode_pkg::OFS_SCAN_CTRL: begin
                    readData = {31'h0, runtimeScanEnable};
                end
                default: readData = 32'h0;
            endcase
        end
    end
endmodule // config_word_decoder
`default_nettype wire

/* testbench/config_word_decoder_chk.sv */
// assertion checker for the configuration word decoder
`default_nettype none
module config_word_decoder_chk (
    input wire logic clock,
    input wire logic reset,
    input wire logic [31:0] nvWordProtectDebug,
    input wire logic [31:0] nvWordClockWatchdog,
    input wire logic [3:0] address,
    input wire logic [31:0] writeData,
    input wire logic writeStrobe,
    input wire logic readStrobe,
    input wire logic [31:0] readData,
    input wire logic watchdogSoftEnable,
    input wire logic configValid,
    input wire cfg_decode_pkg::protect_cfg_t protectCfg,
    input wire cfg_decode_pkg::clock_cfg_t clockCfg,
    input wire logic watchdogRunning,
    input wire logic runtimeScanEnable,
    input wire logic clockOutDrive
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    // once final, decode never moves until the next reset
    valid_hold_a: assert property (configValid |=> configValid)
        else $error("configValid dropped");
    cfg_stable_a: assert property (configValid |=>
        $stable(protectCfg) && $stable(clockCfg)) else $error("cfg moved");
    // read data only in the cycle after a read strobe
    read_idle_a: assert property (!$past(readStrobe) |->
        readData == 32'h0) else $error("stray read data");
    // status shows the flops as they stand in the answer cycle, so a
    // read at the edge where the decode goes final sees the new values
    status_read_a: assert property (
        readStrobe && address == cfg_decode_pkg::OFS_STATUS |=>
        readData == {30'h0, configValid, runtimeScanEnable})
        else $error("status read wrong");
    wdt_run_a: assert property (watchdogRunning == (configValid &&
        (clockCfg.watchdogForced || watchdogSoftEnable)))
        else $error("watchdog run wrong");
    clock_out_signal_mode_a: assert property (clockCfg.clockOutActive |->
        clockCfg.primaryOscMode inside {cfg_decode_pkg::POSC_OFF,
        cfg_decode_pkg::POSC_EXT_CLK}) else $error("clock out mode");
    clock_out_signal_drive_a: assert property (clockOutDrive ==
        (configValid && clockCfg.clockOutActive)) else $error("clock out");
    // decode relations, judged where the words are still on the inputs
    page_limit_a: assert property ($rose(configValid) |->
        protectCfg.protectLimit == {~nvWordProtectDebug[19:10], 10'h000})
        else $error("limit wrong");
    page_on_a: assert property ($rose(configValid) |->
        protectCfg.pageProtectOn == (nvWordProtectDebug[19:10] != 10'h3ff
        && !nvWordProtectDebug[24])) else $error("page protect wrong");
    debugger_on_a: assert property ($rose(configValid) |->
        protectCfg.debuggerEnable == (nvWordProtectDebug[28]
        && !nvWordProtectDebug[1])) else $error("debugger wrong");
    scan_seed_a: assert property ($rose(configValid) |->
        runtimeScanEnable == nvWordProtectDebug[2]) else $error("scan seed");
    bus_div_a: assert property ($rose(configValid) |->
        clockCfg.periphDivisor == 4'h1 << nvWordClockWatchdog[13:12])
        else $error("divisor wrong");
    clk_switch_a: assert property ($rose(configValid) |->
        clockCfg.clockSwitchEn == !nvWordClockWatchdog[15])
        else $error("switching wrong");
    ps_clamp_a: assert property ($rose(configValid) |->
        clockCfg.postscaleShift == (nvWordClockWatchdog[20:16] > 5'h14 ?
        5'h14 : nvWordClockWatchdog[20:16])) else $error("postscale wrong");
endmodule // config_word_decoder_chk
`default_nettype wire

/* testbench/cfg_programmer_model.sv */
// model of the programmer that fills the two configuration words
`default_nettype none
module cfg_programmer_model (
    input wire logic [31:0] protectFields,
    input wire logic [31:0] clockFields,
    output logic [31:0] wordProtect,
    output logic [31:0] wordClock
);
    timeunit 1ns;
    timeprecision 1ps;
    // reserved positions: ones, but the top bit of word 0 stays clear
    localparam logic [31:0] RSV0 = 32'h6ef003e0;
    localparam logic [31:0] RSV1 = 32'hfc200858;
    wire logic primaryOff;
    // primary first but switched off would leave the chip clockless
    assign primaryOff = clockFields[2:0] == 3'h2 && clockFields[9:8] == 2'h3;
    assign wordProtect = (protectFields & 32'h7fffffff) | RSV0;
    assign wordClock = (clockFields | RSV1) & ~(32'(primaryOff) << 8);
endmodule // cfg_programmer_model
`default_nettype wire

/* testbench/tb_config_word_decoder.sv */
// self-checking bench for the configuration word decoder
`default_nettype none
`define CHK(what, exp, got) begin compares++; if ((got) !== (exp)) begin \
    n_mismatch++; $display("[FAIL] %s exp %h got %h", what, exp, got); end end
module tb_config_word_decoder;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic [31:0] pf = 32'h0;
    logic [31:0] cf = 32'h0;
    logic [31:0] w0;
    logic [31:0] w1;
    logic [3:0] address = 4'h0;
    logic [31:0] writeData = 32'h0;
    logic writeStrobe = 1'b0;
    logic readStrobe = 1'b0;
    logic [31:0] readData;
    logic watchdogSoftEnable = 1'b0;
    logic configValid;
    cfg_decode_pkg::protect_cfg_t pc;
    cfg_decode_pkg::clock_cfg_t cc;
    logic watchdogRunning;
    logic runtimeScanEnable;
    logic clockOutDrive;
    int n_mismatch = 0;
    int compares = 0;
    int cycles = 0;
    logic [2:0] winExp [0:3] = '{cfg_decode_pkg::WIN_75,
        cfg_decode_pkg::WIN_50, cfg_decode_pkg::WIN_37, cfg_decode_pkg::WIN_25};

    cfg_programmer_model prog_u (.protectFields(pf), .clockFields(cf),
        .wordProtect(w0), .wordClock(w1));
    config_word_decoder dut_u (.clock(clock), .reset(reset),
        .nvWordProtectDebug(w0), .nvWordClockWatchdog(w1),
        .address(address), .writeData(writeData), .writeStrobe(writeStrobe),
        .readStrobe(readStrobe), .readData(readData),
        .watchdogSoftEnable(watchdogSoftEnable), .configValid(configValid),
        .protectCfg(pc), .clockCfg(cc), .watchdogRunning(watchdogRunning),
        .runtimeScanEnable(runtimeScanEnable), .clockOutDrive(clockOutDrive));

    always #2 clock = ~clock;
    // hang guard: a full run needs well under a thousand cycles
    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            stop_test();
        end
    end

    task stop_test;
        if (n_mismatch == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task restart;
        reset <= 1'b1;
        repeat (2) @(posedge clock);
        reset <= 1'b0;
    endtask
    task wait_valid;
        int k;
        k = 0;
        while (configValid !== 1'b1 && k < 10) begin
            @(posedge clock);
            k++;
        end
        `CHK("configValid", 1'b1, configValid)
    endtask
    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clock);
        address <= a;
        writeData <= d;
        writeStrobe <= 1'b1;
        @(posedge clock);
        writeStrobe <= 1'b0;
    endtask
    // data stand only in the cycle after the strobe edge
    task rdchk(input logic [3:0] a, input logic [31:0] e);
        @(posedge clock);
        address <= a;
        readStrobe <= 1'b1;
        @(posedge clock);
        readStrobe <= 1'b0;
        #1;
        `CHK("readData", e, readData)
    endtask

    // every code of each field of both words but the ten-bit page field, one reset per pattern
    task t_decode_sweep;
        logic [4:0] c;
        logic [9:0] page_write_protect_count;
        logic co;
        for (int i = 0; i < 32; i++) begin
            c = 5'(i);
            page_write_protect_count = (i == 0) ? 10'h3ff : (i == 1) ? 10'h000 : 10'h3ff - 10'(i);
            pf <= {3'h0, c[1], 3'h0, c[0], 4'h0, page_write_protect_count, 5'h0, c[1:0], c[2],
                c[4:3]};
            cf <= {6'h0, c[1:0], c[0], c[1], 1'b0, c, c[1:0], c[1:0], 1'b0,
                c[4], c[3:2], c[2], 1'b0, c[3], 2'h0, c[2:0]};
            watchdogSoftEnable <= c[3];
            restart();
            wait_valid();
            co = !w1[10] && (w1[9:8] == 2'h3 || w1[9:8] == 2'h0);
            `CHK("limit", {~w0[19:10], 10'h000}, pc.protectLimit)
            `CHK("pageOn", w0[19:10] != 10'h3ff && !w0[24], pc.pageProtectOn)
            `CHK("bootWr", w0[24], pc.bootWritable)
            `CHK("codeProt", !w0[28], pc.codeProtectOn)
            `CHK("pair", 2'h0 - w0[4:3], pc.debugPair)
            `CHK("scan", {2{w0[2]}}, {pc.scanPortEnable, runtimeScanEnable})
            `CHK("debugger", w0[28] && !w0[1], pc.debuggerEnable)
            `CHK("window", winExp[w1[25:24]], cc.windowEighths)
            `CHK("wdt", {w1[23], w1[23] | c[3]}, {cc.watchdogForced, watchdogRunning})
            `CHK("winMode", !w1[22], cc.windowMode)
            `CHK("post", w1[20:16] > 5'h14 ? 5'h14 : w1[20:16], cc.postscaleShift)
            `CHK("switch", !w1[15], cc.clockSwitchEn)
            `CHK("failSafe", w1[15:14] == 2'h0, cc.failSafeEn)
            `CHK("pbdiv", 4'h1 << w1[13:12], cc.periphDivisor)
            `CHK("clock_out_signal", {co, co}, {cc.clockOutActive, clockOutDrive})
            `CHK("posc", w1[9:8], cc.primaryOscMode)
            `CHK("twoSpeed", w1[7], cc.twoSpeedStartup)
            `CHK("sosc", w1[5], cc.secondaryOscEn)
            `CHK("nosc", w1[2:0], cc.initialOsc)
        end
    endtask
    // read-only words, unmapped place, scan control and status
    task t_registers;
        rdchk(4'h0, w0);
        rdchk(4'h4, w1);
        wr(4'h0, 32'h0);
        wr(4'h4, 32'h0);
        rdchk(4'h0, w0);
        rdchk(4'h4, w1);
        rdchk(4'h2, 32'h0);
        wr(4'hc, 32'h0);
        rdchk(4'h8, 32'h2);
        wr(4'hc, 32'h1);
        rdchk(4'hc, 32'h1);
        rdchk(4'h8, 32'h3);
    endtask
    // later changes of the words must not reach the decode
    task t_hold;
        logic [31:0] o0;
        cfg_decode_pkg::protect_cfg_t sp;
        cfg_decode_pkg::clock_cfg_t sc;
        o0 = w0;
        sp = pc;
        sc = cc;
        @(posedge clock);
        pf <= ~pf;
        cf <= ~cf;
        repeat (4) @(posedge clock);
        `CHK("hold", {sp, sc}, {pc, cc})
        rdchk(4'h0, o0);
    endtask
    // scan control written before decode is final is ignored;
    // once final, software owns the bit
    task t_early;
        @(posedge clock);
        restart();
        wr(4'hc, {31'h0, ~w0[2]});
        wait_valid();
        `CHK("scanSeed", w0[2], runtimeScanEnable)
        wr(4'hc, {31'h0, ~w0[2]});
        #1;
        `CHK("scanOwn", ~w0[2], runtimeScanEnable)
    endtask

    initial begin
        t_decode_sweep();
        t_registers();
        t_hold();
        t_early();
        stop_test();
    end
endmodule // tb_config_word_decoder
bind config_word_decoder config_word_decoder_chk chk_u (.clock(clock),
    .reset(reset), .nvWordProtectDebug(nvWordProtectDebug),
    .nvWordClockWatchdog(nvWordClockWatchdog), .address(address),
    .writeData(writeData), .writeStrobe(writeStrobe),
    .readStrobe(readStrobe), .readData(readData),
    .watchdogSoftEnable(watchdogSoftEnable), .configValid(configValid),
    .protectCfg(protectCfg), .clockCfg(clockCfg),
    .watchdogRunning(watchdogRunning),
    .runtimeScanEnable(runtimeScanEnable), .clockOutDrive(clockOutDrive));
`default_nettype wire
